// file: design/rcr_pkg.sv
// constants and types of the reset controller with supply monitor
package rcr_pkg;
  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] MON_CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] RST_SRC_OFS = 8'h04;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MON_EN_BIT = 7;
  localparam int MON_STAT_BIT = 6;
  localparam int MON_LVL_BIT = 5;
  localparam int OTHER_RSF_BIT = 0;
  localparam int POR_FLAG_BIT = 1;
  localparam int SW_RSF_BIT = 4;
  localparam int FERR_BIT = 6;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic MON_EN_RST = 1'b1;
  localparam logic MON_LVL_RST = 1'b0;
  localparam logic MON_SEL_RST = 1'b0;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] PORT_LATCH_RST = 8'hff;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam real CLK_PERIOD_NS = 8.0;
  localparam real POR_DELAY_MS = 0.3;
  localparam int POR_DELAY_CYC = int'($floor(POR_DELAY_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int WDT_DIV = 12;
  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [4:0]
  {
    ST_POR_HOLD = 5'b00001,
    ST_POR_WAIT = 5'b00010,
    ST_RUN = 5'b00100,
    ST_MON_HOLD = 5'b01000,
    ST_SRC_RST = 5'b10000
  } rcr_state_e;
endpackage

// file: design/rcr_sync.sv
// two-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
module rcr_sync
  import rcr_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // rcr_sync

// file: design/rcr_por_delay.sv
// release delay counter: done after CYCLES cycles of run
`timescale 1ns/1ns
module rcr_por_delay
  import rcr_pkg::*;
#(
  parameter int CYCLES = POR_DELAY_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (!run)
      cnt_d = '0;
    else if (cnt_q != LAST)
      cnt_d = cnt_q + CW'(1);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign done = run && (cnt_q == LAST);
endmodule // rcr_por_delay

// file: design/rcr_top.sv
// reset controller: power-on reset, supply monitor, register slave
`timescale 1ns/1ns
module rcr_top
  import rcr_pkg::*;
#(
  parameter int POR_DELAY_CYCLES = POR_DELAY_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic supply_above_rst,
  input wire logic supply_monitor_out,
  input wire logic other_reset_req,
  input wire logic flash_write_req,
  output logic flash_write_ok,
  input wire logic clk_switch_ext,
  input wire logic wdt_disable,
  input wire logic port_wr,
  input wire logic [7:0] port_wdata,
  output logic supply_monitor_enable,
  output logic supply_monitor_level_select,
  output logic core_reset,
  output logic rst_pin_o,
  output logic rst_pin_oe,
  output logic [7:0] port_latch_value,
  output logic port_open_drain,
  output logic weak_pullup_en,
  output logic clk_sel_internal,
  output logic wdt_enable,
  output logic wdt_tick,
  output logic [15:0] reset_vector,
  output logic data_mem_undefined
);
  // ---------------------------------------------------------------
  // synchronised analog inputs and release delay
  // ---------------------------------------------------------------
  logic vdd_ok_s;
  logic mon_good_s;
  logic por_done;
  rcr_state_e state_q;
  rcr_state_e state_d;

  rcr_sync #(.W(2)) u_sync
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({supply_above_rst, supply_monitor_out}),
    .q({vdd_ok_s, mon_good_s})
  );

  rcr_por_delay #(.CYCLES(POR_DELAY_CYCLES)) u_delay
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(state_q == ST_POR_WAIT),
    .done(por_done)
  );

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == MON_CTRL_OFS) || (a == RST_SRC_OFS);
  endfunction

  // ---------------------------------------------------------------
  // register bus slave
  // ---------------------------------------------------------------
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic wlane_q, wlane_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic wr_fire;
  logic mon_en_q, mon_en_d, mon_lvl_q, mon_lvl_d, mon_sel_q, mon_sel_d;
  logic [7:0] flags_q, flags_d, cause_q, cause_d;
  logic [7:0] mon_ctrl_rd, rst_src_rd;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

  always_comb
  begin
    mon_ctrl_rd = 8'h00;
    mon_ctrl_rd[MON_EN_BIT] = mon_en_q;
    mon_ctrl_rd[MON_STAT_BIT] = mon_good_s;
    mon_ctrl_rd[MON_LVL_BIT] = mon_lvl_q;
    rst_src_rd = flags_q;
  end

  always_comb
  begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wbyte_d = wbyte_q;
    wlane_d = wlane_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      wbyte_d = s_axi_wdata[7:0];
      wlane_d = s_axi_wstrb[0];
    end
    if (wr_fire)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid_q && s_axi_bready)
      bvalid_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_d = '0;
      if (s_axi_araddr == MON_CTRL_OFS)
        rdata_d[7:0] = mon_ctrl_rd;
      else if (s_axi_araddr == RST_SRC_OFS)
        rdata_d[7:0] = rst_src_rd;
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_d = 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // ---------------------------------------------------------------
  // monitor control and reset sequencing
  // ---------------------------------------------------------------
  logic in_reset_d, pin_drive_d, sw_wr, ctl_wr, src_wr;
  logic mon_trip, flash_bad;
  logic core_reset_q, pin_oe_q, clk_int_q, clk_int_d, wdt_en_q, wdt_en_d;
  logic [7:0] port_q, port_d;
  logic [3:0] wdt_cnt_q, wdt_cnt_d;
  logic wdt_tick_q, wdt_tick_d;

  // writes are dropped while the core is held in reset
  assign ctl_wr = wr_fire && wlane_q && !core_reset_q && awaddr_q == MON_CTRL_OFS;
  assign src_wr = wr_fire && wlane_q && !core_reset_q && awaddr_q == RST_SRC_OFS;
  assign sw_wr = src_wr && wbyte_q[SW_RSF_BIT];
  assign mon_trip = mon_en_q && mon_sel_q && !mon_good_s;
  assign flash_bad = flash_write_req && !mon_en_q;
  assign flash_write_ok = flash_write_req && mon_en_q && !core_reset_q;

  always_comb
  begin
    state_d = state_q;
    flags_d = flags_q;
    cause_d = cause_q;
    unique case (state_q)
      ST_POR_HOLD:
        if (vdd_ok_s)
          state_d = ST_POR_WAIT;
      ST_POR_WAIT:
        if (!vdd_ok_s)
          state_d = ST_POR_HOLD;
        else if (por_done)
        begin
          state_d = ST_RUN;
          flags_d = FLAGS_RST;
          flags_d[POR_FLAG_BIT] = 1'b1;
        end
      ST_RUN:
        if (!vdd_ok_s)
          state_d = ST_POR_HOLD;
        else if (mon_trip)
          state_d = ST_MON_HOLD;
        else if (flash_bad || sw_wr || other_reset_req)
        begin
          state_d = ST_SRC_RST;
          cause_d = FLAGS_RST;
          if (flash_bad)
            cause_d[FERR_BIT] = 1'b1;
          else if (sw_wr)
            cause_d[SW_RSF_BIT] = 1'b1;
          else
            cause_d[OTHER_RSF_BIT] = 1'b1;
        end
      ST_MON_HOLD:
        if (!vdd_ok_s)
          state_d = ST_POR_HOLD;
        else if (mon_good_s)
        begin
          state_d = ST_RUN;
          flags_d = FLAGS_RST;
        end
      ST_SRC_RST:
      begin
        state_d = ST_RUN;
        flags_d = cause_q;
      end
    endcase
  end

  assign in_reset_d = state_d != ST_RUN;
  assign pin_drive_d = state_d inside {ST_POR_HOLD, ST_POR_WAIT, ST_MON_HOLD};

  always_comb
  begin
    mon_en_d = mon_en_q;
    mon_lvl_d = mon_lvl_q;
    mon_sel_d = mon_sel_q;
    if (ctl_wr)
    begin
      mon_en_d = wbyte_q[MON_EN_BIT];
      mon_lvl_d = wbyte_q[MON_LVL_BIT];
    end
    if (src_wr)
      mon_sel_d = wbyte_q[POR_FLAG_BIT];
    if (in_reset_d)
      mon_lvl_d = MON_LVL_RST;
    if (state_d == ST_POR_HOLD || state_d == ST_POR_WAIT)
    begin
      mon_en_d = MON_EN_RST;
      mon_sel_d = MON_SEL_RST;
    end
  end

  always_comb
  begin
    port_d = port_q;
    clk_int_d = clk_int_q;
    wdt_en_d = wdt_en_q;
    wdt_cnt_d = (wdt_cnt_q == 4'(WDT_DIV - 1)) ? 4'h0 : wdt_cnt_q + 4'h1;
    wdt_tick_d = !in_reset_d && wdt_en_q && wdt_cnt_q == 4'(WDT_DIV - 1);
    if (port_wr)
      port_d = port_wdata;
    if (clk_switch_ext)
      clk_int_d = 1'b0;
    if (wdt_disable)
      wdt_en_d = 1'b0;
    if (in_reset_d)
    begin
      port_d = PORT_LATCH_RST;
      clk_int_d = 1'b1;
      wdt_en_d = 1'b1;
      wdt_cnt_d = 4'h0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= '0;
      state_q <= ST_POR_HOLD;
      flags_q <= FLAGS_RST;
      cause_q <= FLAGS_RST;
      mon_en_q <= MON_EN_RST;
      mon_lvl_q <= MON_LVL_RST;
      mon_sel_q <= MON_SEL_RST;
      core_reset_q <= 1'b1;
      pin_oe_q <= 1'b1;
      port_q <= PORT_LATCH_RST;
      clk_int_q <= 1'b1;
      wdt_en_q <= 1'b1;
      wdt_cnt_q <= 4'h0;
      wdt_tick_q <= 1'b0;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wbyte_q <= wbyte_d;
      wlane_q <= wlane_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      state_q <= state_d;
      flags_q <= flags_d;
      cause_q <= cause_d;
      mon_en_q <= mon_en_d;
      mon_lvl_q <= mon_lvl_d;
      mon_sel_q <= mon_sel_d;
      core_reset_q <= in_reset_d;
      pin_oe_q <= pin_drive_d;
      port_q <= port_d;
      clk_int_q <= clk_int_d;
      wdt_en_q <= wdt_en_d;
      wdt_cnt_q <= wdt_cnt_d;
      wdt_tick_q <= wdt_tick_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign supply_monitor_enable = mon_en_q;
  assign supply_monitor_level_select = mon_lvl_q;
  assign core_reset = core_reset_q;
  assign rst_pin_o = 1'b0;
  assign rst_pin_oe = pin_oe_q;
  assign port_latch_value = port_q;
  assign port_open_drain = core_reset_q;
  assign weak_pullup_en = 1'b1;
  assign clk_sel_internal = clk_int_q;
  assign wdt_enable = wdt_en_q;
  assign wdt_tick = wdt_tick_q;
  assign reset_vector = RESET_VECTOR;
  assign data_mem_undefined = flags_q[POR_FLAG_BIT];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles since the last watchdog tick, f when none seen since reset
  logic [3:0] tick_gap_q;
  logic [3:0] tick_gap_d;

  always_comb
  begin
    tick_gap_d = tick_gap_q;
    if (core_reset)
      tick_gap_d = 4'hf;
    else if (wdt_tick)
      tick_gap_d = 4'h0;
    else if (tick_gap_q != 4'hf)
      tick_gap_d = tick_gap_q + 4'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_gap_q <= 4'hf;
    else
      tick_gap_q <= tick_gap_d;
  end

  chk_core_halt: assert property (state_q != ST_RUN |-> core_reset)
    else $error("core not held while in reset state");
  chk_port_ones: assert property (core_reset |-> port_latch_value == 8'hff && port_open_drain)
    else $error("port latches not all ones in reset");
  chk_pin_low: assert property (state_q inside {ST_POR_HOLD, ST_POR_WAIT, ST_MON_HOLD} |-> rst_pin_oe)
    else $error("reset pin not driven low");
  chk_exit_clock: assert property ($fell(core_reset) |-> clk_sel_internal && wdt_enable
    && reset_vector == 16'h0000)
    else $error("bad clock, watchdog or vector at reset exit");
  chk_wdt_period: assert property (wdt_tick && tick_gap_q != 4'hf
    |-> tick_gap_q == 4'(WDT_DIV - 1))
    else $error("watchdog tick period not twelve");
  chk_wdt_due: assert property (!core_reset && wdt_enable && tick_gap_q == 4'(WDT_DIV - 1)
    |-> wdt_tick)
    else $error("watchdog tick missing after twelve cycles");
  chk_por_delay: assert property (state_q == ST_POR_WAIT && !por_done |=> state_q != ST_RUN)
    else $error("released before power-on delay");
  chk_por_flag: assert property (state_q == ST_POR_WAIT && state_d == ST_RUN
    |=> flags_q[POR_FLAG_BIT] ##1 !core_reset)
    else $error("power-on flag not set on exit");
  chk_mon_keep: assert property (state_q == ST_SRC_RST |=> $stable(mon_en_q))
    else $error("monitor enable changed by other reset");
  chk_mon_trip: assert property (state_q == ST_RUN && vdd_ok_s && mon_trip
    |=> state_q == ST_MON_HOLD && core_reset && rst_pin_oe)
    else $error("monitor trip did not hold core");
  chk_mon_fast: assert property (state_q == ST_MON_HOLD && vdd_ok_s && mon_good_s
    |=> !core_reset)
    else $error("monitor release delayed");
  chk_flash_err: assert property (state_q == ST_RUN && vdd_ok_s && !mon_trip && flash_bad
    |-> !flash_write_ok ##1 core_reset ##1 flags_q[FERR_BIT])
    else $error("flash write with monitor off not trapped");
endmodule // rcr_top

// file: dv/rcr_supply_model.sv
// analog supply comparators and open-drain reset pin beside the controller
`timescale 1ns/1ns
module rcr_supply_model
#(
  parameter int RST_MV = 1700,
  parameter int LOW_MV = 1800,
  parameter int HIGH_MV = 2000
)
(
  input wire logic aclk,
  input wire logic [11:0] vdd_mv,
  input wire logic level_high,
  input wire logic rst_pin_o,
  input wire logic rst_pin_oe,
  output logic supply_above_rst,
  output logic supply_monitor_out,
  output logic rst_pin
);
  logic [11:0] thr_mv;
  assign thr_mv = level_high ? 12'(HIGH_MV) : 12'(LOW_MV);
  // comparators settle just after the clock edge
  always_ff @(posedge aclk)
  begin
    supply_above_rst <= vdd_mv > 12'(RST_MV);
    supply_monitor_out <= vdd_mv > thr_mv;
  end
  // external pull-up holds the pin high when released
  assign rst_pin = rst_pin_oe ? rst_pin_o : 1'b1;
endmodule // rcr_supply_model

// file: dv/tb_top.sv
// self-checking testbench of the reset controller with supply monitor
`timescale 1ns/1ns
module tb_top;
  import rcr_pkg::*;
  localparam int POR_CYC = 20;
  localparam int TMO = 5000;
  logic aclk, aresetn;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic supply_above_rst, supply_monitor_out, other_reset_req, flash_write_req, flash_write_ok;
  logic clk_switch_ext, wdt_disable, port_wr, supply_monitor_enable, supply_monitor_level_select;
  logic core_reset, rst_pin_o, rst_pin_oe, port_open_drain, weak_pullup_en, clk_sel_internal;
  logic wdt_enable, wdt_tick, data_mem_undefined, rst_pin;
  logic [7:0] port_wdata, port_latch_value;
  logic [15:0] reset_vector;
  logic [11:0] vdd_mv;
  int fail_count, total_checks, cyc, rst_rises;

  rcr_top #(.POR_DELAY_CYCLES(POR_CYC)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .supply_above_rst, .supply_monitor_out,
    .other_reset_req, .flash_write_req, .flash_write_ok, .clk_switch_ext, .wdt_disable, .port_wr,
    .port_wdata, .supply_monitor_enable, .supply_monitor_level_select, .core_reset, .rst_pin_o,
    .rst_pin_oe, .port_latch_value, .port_open_drain, .weak_pullup_en, .clk_sel_internal,
    .wdt_enable, .wdt_tick, .reset_vector, .data_mem_undefined);

  rcr_supply_model u_sup (.aclk, .vdd_mv, .level_high(supply_monitor_level_select), .rst_pin_o,
    .rst_pin_oe, .supply_above_rst, .supply_monitor_out, .rst_pin);

  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if ($rose(core_reset))
      rst_rises <= rst_rises + 1;
    if (cyc == TMO)
    begin
      fail_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid)
        break;
    end
    check(s_axi_bresp, er);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid)
        break;
    end
    check(s_axi_rdata, e);
    check(s_axi_rresp, er);
  endtask

  task automatic wait_rst(input logic lvl, output int n);
    n = 0;
    while (core_reset !== lvl)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic pulse_in(input int sel);
    case (sel)
      0: other_reset_req <= 1'b1;
      1: flash_write_req <= 1'b1;
      default:
      begin
        clk_switch_ext <= 1'b1;
        wdt_disable <= 1'b1;
        port_wr <= 1'b1;
      end
    endcase
    @(posedge aclk);
    {other_reset_req, flash_write_req, clk_switch_ext, wdt_disable, port_wr} <= 5'h00;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_power_on();
    int n;
    @(posedge aclk);
    check({core_reset, rst_pin}, 2'b10);
    check(port_latch_value, PORT_LATCH_RST);
    check({port_open_drain, weak_pullup_en, clk_sel_internal, wdt_enable}, 4'hf);
    check(supply_monitor_enable, 1);
    vdd_mv <= 12'd3300;
    wait_rst(1'b0, n);
    check(n > POR_CYC && n < POR_CYC + 12, 1);
    check({rst_pin, clk_sel_internal, wdt_enable, data_mem_undefined}, 4'hf);
    check(reset_vector, RESET_VECTOR);
    rd_chk(RST_SRC_OFS, 32'h02);
    rd_chk(MON_CTRL_OFS, 32'hc0);
    rd_chk(8'h08, 32'h0, RESP_SLVERR);
    wr(8'h0c, 32'hff, RESP_SLVERR);
  endtask

  task automatic t_threshold();
    wr(MON_CTRL_OFS, 32'ha0);
    check(supply_monitor_level_select, 1);
    vdd_mv <= 12'd1900;
    tick(5);
    rd_chk(MON_CTRL_OFS, 32'ha0);
    check(core_reset, 0);
    vdd_mv <= 12'd3300;
    tick(5);
  endtask

  task automatic t_brownout();
    int n;
    wr(RST_SRC_OFS, 32'h02);
    vdd_mv <= 12'd1750;
    wait_rst(1'b1, n);
    tick(6);
    check({core_reset, rst_pin}, 2'b10);
    vdd_mv <= 12'd3300;
    wait_rst(1'b0, n);
    check(n < 8, 1);
    check(data_mem_undefined, 0);
    rd_chk(RST_SRC_OFS, 32'h00);
    rd_chk(MON_CTRL_OFS, 32'hc0);
  endtask

  task automatic t_soft_reset();
    int r;
    r = rst_rises;
    port_wdata <= 8'h5a;
    pulse_in(2);
    tick(2);
    check({clk_sel_internal, wdt_enable, port_latch_value}, {2'b00, 8'h5a});
    wr(MON_CTRL_OFS, 32'h00);
    wr(RST_SRC_OFS, 32'h10);
    tick(4);
    check(32'(rst_rises - r), 1);
    check({clk_sel_internal, wdt_enable, port_latch_value}, {2'b11, 8'hff});
    rd_chk(RST_SRC_OFS, 32'h10);
    rd_chk(MON_CTRL_OFS, 32'h40);
    check(supply_monitor_enable, 0);
  endtask

  task automatic t_flash();
    int r;
    r = rst_rises;
    flash_write_req <= 1'b1;
    @(posedge aclk);
    check(flash_write_ok, 0);
    flash_write_req <= 1'b0;
    tick(4);
    check(32'(rst_rises - r), 1);
    rd_chk(RST_SRC_OFS, 32'h40);
    wr(MON_CTRL_OFS, 32'ha0);
    wr(RST_SRC_OFS, 32'h02);
    flash_write_req <= 1'b1;
    @(posedge aclk);
    check(flash_write_ok, 1);
    flash_write_req <= 1'b0;
    tick(4);
    check(32'(rst_rises - r), 1);
  endtask

  task automatic t_other_and_wdt();
    int n;
    pulse_in(0);
    tick(4);
    rd_chk(RST_SRC_OFS, 32'h01);
    rd_chk(MON_CTRL_OFS, 32'hc0);
    n = 0;
    while (wdt_tick !== 1'b1)
      @(posedge aclk);
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (wdt_tick !== 1'b1);
    check(n, WDT_DIV);
  endtask

  task automatic t_repower();
    int n;
    vdd_mv <= 12'd0;
    wait_rst(1'b1, n);
    tick(2);
    check(rst_pin, 0);
    vdd_mv <= 12'd1750;
    wait_rst(1'b0, n);
    tick(8);
    check(core_reset, 0);
    check(data_mem_undefined, 1);
    rd_chk(RST_SRC_OFS, 32'h02);
    rd_chk(MON_CTRL_OFS, 32'h80);
  endtask

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, port_wr} = 5'h00;
    {other_reset_req, flash_write_req, clk_switch_ext, wdt_disable} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, port_wdata} = 24'h000000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    {s_axi_bready, s_axi_rready} = 2'b11;
    vdd_mv = 12'd0;
    {fail_count, total_checks, cyc, rst_rises} = {4{32'h0}};
    tick(4);
    aresetn <= 1'b1;
    t_power_on();
    t_threshold();
    t_brownout();
    t_soft_reset();
    t_flash();
    t_other_and_wdt();
    t_repower();
    end_of_test();
  end
endmodule // tb_top
